// ---- logic/fss_pkg.sv ----
// Purpose: Constants and types for the frequency select latch and serial slave
// Assumes: 40 MHz core clock, APB register access, 8 serial register bytes
// Notes:   Serial byte defaults are packed low byte first
`default_nettype none
package fss_pkg;

	// Serial slave address, write direction bit included
	localparam logic [7:0]  SER_ADDR_BYTE = 8'hD2;
	localparam int          SER_BYTES     = 8;
	localparam logic [7:0]  SER_COUNT     = 8'h08;
	localparam logic [63:0] SER_DEFAULTS  = 64'h0000_0000_FF00_7F40;
	localparam int          CMD_BYTE_BIT  = 7;
	localparam int          FS_FIRST_POS  = 0;
	localparam int          FS_SECOND_POS = 1;

	// APB map
	localparam logic [7:0]  OFS_CTRL      = 8'h00;
	localparam logic [7:0]  OFS_STATUS    = 8'h04;
	localparam logic [7:0]  OFS_WIN_BASE  = 8'h20;
	localparam logic [7:0]  OFS_WIN_LAST  = 8'h3C;
	localparam logic        CTRL_EN_RST   = 1'b1;
	localparam int          ST_LATCHED    = 0;
	localparam int          ST_TEST       = 1;
	localparam int          ST_FS_LO      = 2;
	localparam int          ST_BUSY       = 4;

	// Synchroniser lanes
	localparam int          LN_STROBE     = 0;
	localparam int          LN_FSA        = 1;
	localparam int          LN_FSB        = 2;
	localparam int          LN_FSB_MID    = 3;
	localparam int          LN_SCL        = 4;
	localparam int          LN_SDA        = 5;
	localparam int          LANES         = 6;

	typedef enum logic [2:0] {
		FSS_IDLE,
		FSS_ADDR,
		FSS_CMD,
		FSS_WR,
		FSS_ACK,
		FSS_RD,
		FSS_MACK,
		FSS_IGNORE
	} fss_state_e;

endpackage
`default_nettype wire

// ---- logic/fss_top.sv ----
// Purpose: Power-good latch of frequency selects plus serial register slave
// Assumes: Strobe, select and serial pins asynchronous to core_clk; serial clock far below 10 MHz
// Notes:   Operation
// Operation
// - On strobe sampled low, capture both selects to choose host frequency.
// - After a valid non-mid capture, ignore strobe and select changes.
// - Second select at mid level on strobe low enters test clock mode.
// - Test mode ignores second select; first picks Hi-Z or ref/N asynchronously.
// - Test mode holds until power cycles; reset leaves it.
// - Serial registers load defaults at power-up; serial access optional.
// - Slave supports byte write, byte read, block write, block read.
// - Block transfers ascend from lowest byte, MSB first, stop after any byte.
// - Slave answers address byte D2h including write bit.
// - Command bit 7 zero means block, one means single byte.
// - Byte offset in command bits 4:0; block commands carry zero offset.
// - Block write sequence: address, command, count, data bytes, each acked.
// - Block read: repeated start, read address, count then data, master acks.
// - Byte write: address, command, one data byte acked, then stop.
// - Byte read: command, repeated start, read address, one byte, stop.
//
// The APB register port and the placing of the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
module fss_top
	import fss_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	input  wire logic        cpu_rail_good_strobe_n,
	input  wire logic        freq_select_first,
	input  wire logic        freq_select_second,
	input  wire logic        freq_select_second_mid,
	input  wire logic        smb_scl,
	input  wire logic        smb_sda_in,
	output logic             smb_sda_out,
	output logic             smb_sda_oe,
	output logic [1:0]       host_freq_sel,
	output logic             freq_latched,
	output logic             test_clock_mode,
	output logic             test_outputs_hiz,
	output logic             test_outputs_refn,
	output logic [63:0]      ser_regs,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr
);

	typedef struct packed {
		logic [LANES-1:0] sync1;
		logic [LANES-1:0] sync2;
		logic [LANES-1:0] prev;
		logic             latched;
		logic             test_mode;
		logic [1:0]       fs;
		logic             en;
		fss_state_e       st;
		fss_state_e       after;
		logic [3:0]       cnt;
		logic [7:0]       shift;
		logic [7:0]       tx;
		logic [4:0]       ptr;
		logic             blk;
		logic             first;
		logic             sda_low;
		logic [31:0]      rdata;
		logic [63:0]      regs;
	} fss_state_s;

	fss_state_s s_r;
	fss_state_s s_nxt;

	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	logic sda_s;
	logic map_hit;
	logic [2:0] win_idx;

	assign sda_s     = s_r.sync2[LN_SDA];
	assign scl_rise  = s_r.sync2[LN_SCL] & ~s_r.prev[LN_SCL];
	assign scl_fall  = ~s_r.sync2[LN_SCL] & s_r.prev[LN_SCL];
	assign start_det = s_r.sync2[LN_SCL] & s_r.prev[LN_SCL] & ~sda_s & s_r.prev[LN_SDA];
	assign stop_det  = s_r.sync2[LN_SCL] & s_r.prev[LN_SCL] & sda_s & ~s_r.prev[LN_SDA];
	assign win_idx   = paddr[4:2];
	assign map_hit   = (paddr == OFS_CTRL) || (paddr == OFS_STATUS) ||
		((paddr >= OFS_WIN_BASE) && (paddr <= OFS_WIN_LAST) && (paddr[1:0] == 2'b00));

	// Register byte as seen by the serial port, with latched selects overlaid
	function automatic logic [7:0] ser_byte(input fss_state_s s, input logic [4:0] idx);
		logic [7:0] b;
		b = 8'h00;
		if (idx < 5'(SER_BYTES)) begin
			b = s.regs[8*idx[2:0] +: 8];
		end
		if (idx == 5'd0) begin
			b[FS_FIRST_POS]  = s.fs[0];
			b[FS_SECOND_POS] = s.fs[1];
		end
		return b;
	endfunction

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		s_nxt       = s_r;
		s_nxt.sync1 = {smb_sda_in, smb_scl, freq_select_second_mid,
			freq_select_second, freq_select_first, cpu_rail_good_strobe_n};
		s_nxt.sync2 = s_r.sync1;
		s_nxt.prev  = s_r.sync2;

		if (!s_r.latched && !s_r.sync2[LN_STROBE]) begin
			s_nxt.latched = 1'b1;
			if (s_r.sync2[LN_FSB_MID]) begin
				s_nxt.test_mode = 1'b1;
			end else begin
				s_nxt.fs = {s_r.sync2[LN_FSB], s_r.sync2[LN_FSA]};
			end
		end

		case (s_r.st)
			FSS_IDLE, FSS_IGNORE: begin
			end
			FSS_ADDR, FSS_CMD, FSS_WR: begin
				if (scl_rise && s_r.cnt < 4'd8) begin
					s_nxt.shift = {s_r.shift[6:0], sda_s};
					s_nxt.cnt   = s_r.cnt + 4'd1;
				end else if (scl_fall && s_r.cnt == 4'd8) begin
					s_nxt.cnt     = 4'd0;
					s_nxt.st      = FSS_ACK;
					s_nxt.sda_low = 1'b1;
					if (s_r.st == FSS_ADDR) begin
						if (s_r.shift[7:1] != SER_ADDR_BYTE[7:1]) begin
							s_nxt.st      = FSS_IGNORE;
							s_nxt.sda_low = 1'b0;
						end else if (s_r.shift[0]) begin
							s_nxt.after = FSS_RD;
							// block read opens with byte count
							if (s_r.blk && s_r.first) begin
								s_nxt.tx    = SER_COUNT;
								s_nxt.first = 1'b0;
							end else begin
								s_nxt.tx  = ser_byte(s_r, s_r.ptr);
								s_nxt.ptr = s_r.ptr + 5'd1;
							end
						end else begin
							s_nxt.after = FSS_CMD;
						end
					end else if (s_r.st == FSS_CMD) begin
						// bit 7 picks block or byte
						s_nxt.blk   = ~s_r.shift[CMD_BYTE_BIT];
						s_nxt.first = ~s_r.shift[CMD_BYTE_BIT];
						// offset from low bits, block starts at zero
						s_nxt.ptr   = s_r.shift[CMD_BYTE_BIT] ? s_r.shift[4:0] : 5'd0;
						s_nxt.after = FSS_WR;
					end else begin
						s_nxt.after = FSS_WR;
						if (s_r.first) begin
							s_nxt.first = 1'b0;
						end else begin
							if (s_r.ptr < 5'(SER_BYTES)) begin
								s_nxt.regs[8*s_r.ptr[2:0] +: 8] = s_r.shift;
							end
							s_nxt.ptr = s_r.ptr + 5'd1;
						end
					end
				end
			end
			FSS_ACK: begin
				if (scl_fall) begin
					s_nxt.st      = s_r.after;
					s_nxt.sda_low = (s_r.after == FSS_RD) ? ~s_r.tx[7] : 1'b0;
				end
			end
			FSS_RD: begin
				if (scl_rise) begin
					s_nxt.cnt = s_r.cnt + 4'd1;
				end else if (scl_fall) begin
					if (s_r.cnt == 4'd8) begin
						s_nxt.sda_low = 1'b0;
						s_nxt.st      = FSS_MACK;
						s_nxt.cnt     = 4'd0;
					end else begin
						s_nxt.sda_low = ~s_r.tx[3'(4'd7 - s_r.cnt)];
					end
				end
			end
			FSS_MACK: begin
				if (scl_rise) begin
					if (sda_s) begin
						// Master NACK closes the read
						s_nxt.st = FSS_IGNORE;
					end else begin
						s_nxt.tx  = ser_byte(s_r, s_r.ptr);
						s_nxt.ptr = s_r.ptr + 5'd1;
					end
				end else if (scl_fall) begin
					s_nxt.st      = FSS_RD;
					s_nxt.sda_low = ~s_r.tx[7];
				end
			end
			default: begin
				s_nxt.st = FSS_IDLE;
			end
		endcase

		// Bus conditions override any bit in flight
		if (stop_det || !s_r.en) begin
			s_nxt.st      = FSS_IDLE;
			s_nxt.sda_low = 1'b0;
		end else if (start_det) begin
			s_nxt.st      = FSS_ADDR;
			s_nxt.cnt     = 4'd0;
			s_nxt.sda_low = 1'b0;
		end

		////////////////////////////////////////////////////////////////////
		// Read data fetched in setup so the access phase answers from a flop
		if (psel && !penable) begin
			s_nxt.rdata = 32'h0000_0000;
			if (paddr == OFS_CTRL) begin
				s_nxt.rdata[0] = s_r.en;
			end else if (paddr == OFS_STATUS) begin
				s_nxt.rdata[ST_LATCHED]         = s_r.latched;
				s_nxt.rdata[ST_TEST]            = s_r.test_mode;
				s_nxt.rdata[ST_FS_LO +: 2]      = s_r.fs;
				s_nxt.rdata[ST_BUSY]            = (s_r.st != FSS_IDLE);
			end else if (map_hit) begin
				s_nxt.rdata[7:0] = ser_byte(s_r, {2'b00, win_idx});
			end
		end
		if (psel && penable && pwrite && paddr == OFS_CTRL) begin
			s_nxt.en = pwdata[0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r       <= '0;
			s_r.sync1 <= '1;
			s_r.sync2 <= '1;
			s_r.prev  <= '1;
			s_r.en    <= CTRL_EN_RST;
			s_r.test_mode <= 1'b0;
			s_r.regs  <= SER_DEFAULTS;
			s_r.st    <= FSS_IDLE;
			s_r.after <= FSS_IDLE;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign smb_sda_out       = 1'b0;
	assign smb_sda_oe        = s_r.sda_low;
	assign host_freq_sel     = s_r.fs;
	assign freq_latched      = s_r.latched;
	assign test_clock_mode   = s_r.test_mode;
	// raw pin, deliberately unsynchronised for async select
	assign test_outputs_hiz  = s_r.test_mode & freq_select_first;
	assign test_outputs_refn = s_r.test_mode & ~freq_select_first;
	assign ser_regs          = s_r.regs;
	assign prdata            = s_r.rdata;
	assign pready            = 1'b1;
	assign pslverr           = psel & penable & ~map_hit;

	////////////////////////////////////////////////////////////////////////
	chk_latch_once: assert property (@(posedge core_clk) disable iff (!rst_n)
		$past(s_r.latched) |-> $stable(s_r.fs) && s_r.latched)
		else $error("latched selects changed");

	chk_latch_capture: assert property (@(posedge core_clk) disable iff (!rst_n)
		$rose(s_r.latched) && !s_r.test_mode |->
			s_r.fs == {$past(s_r.sync2[LN_FSB]), $past(s_r.sync2[LN_FSA])})
		else $error("selects not captured at strobe");

	chk_test_entry: assert property (@(posedge core_clk) disable iff (!rst_n)
		$rose(s_r.test_mode) |-> $past(s_r.sync2[LN_FSB_MID]) && !$past(s_r.sync2[LN_STROBE]))
		else $error("test mode without mid level");

	chk_test_sticky: assert property (@(posedge core_clk) disable iff (!rst_n)
		s_r.test_mode |=> s_r.test_mode)
		else $error("test mode left without power cycle");

	chk_hiz_select: assert property (@(posedge core_clk) disable iff (!rst_n)
		s_r.test_mode |-> test_outputs_hiz == freq_select_first && test_outputs_refn != test_outputs_hiz)
		else $error("test output select wrong");

	chk_foreign_nack: assert property (@(posedge core_clk) disable iff (!rst_n)
		scl_fall && s_r.st == FSS_ADDR && s_r.cnt == 4'd8 && s_r.en && !stop_det && !start_det &&
			s_r.shift[7:1] != SER_ADDR_BYTE[7:1] |=> !smb_sda_oe && s_r.st == FSS_IGNORE)
		else $error("foreign address acknowledged");

	chk_own_ack: assert property (@(posedge core_clk) disable iff (!rst_n)
		scl_fall && s_r.st == FSS_ADDR && s_r.cnt == 4'd8 && s_r.en && !stop_det && !start_det &&
			s_r.shift[7:1] == SER_ADDR_BYTE[7:1] |=> smb_sda_oe && s_r.st == FSS_ACK)
		else $error("own address not acknowledged");

	chk_cmd_mode: assert property (@(posedge core_clk) disable iff (!rst_n)
		scl_fall && s_r.st == FSS_CMD && s_r.cnt == 4'd8 && s_r.en && !stop_det && !start_det |=>
			s_r.blk == !$past(s_r.shift[7]) &&
			s_r.ptr == ($past(s_r.shift[7]) ? $past(s_r.shift[4:0]) : 5'd0))
		else $error("command decode wrong");

	chk_ptr_ascend: assert property (@(posedge core_clk) disable iff (!rst_n)
		scl_fall && s_r.st == FSS_WR && s_r.cnt == 4'd8 && !s_r.first && s_r.en &&
			!stop_det && !start_det |=> s_r.ptr == $past(s_r.ptr) + 5'd1)
		else $error("write pointer not ascending");

endmodule
`default_nettype wire

// ---- dv/fss_smb_host.sv ----
// Purpose: Serial bus host model driving the slave's clock and data
// Assumes: Data wire has a pull-up; half period of ten core cycles
// Notes:   Tasks are called from the bench
`timescale 1ns/100ps
`default_nettype none
module fss_smb_host (
	input  wire logic core_clk,
	input  wire logic sda,
	output logic      scl,
	output logic      sda_low
);
	localparam int HALF = 10;
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic hp();
		repeat (HALF) @(posedge core_clk);
	endtask
	// Serves as repeated start too: data released before clock rises
	task automatic start();
		sda_low <= 1'b0;
		hp();
		scl <= 1'b1;
		hp();
		sda_low <= 1'b1;
		hp();
		scl <= 1'b0;
		hp();
	endtask
	task automatic stop();
		sda_low <= 1'b1;
		hp();
		scl <= 1'b1;
		hp();
		sda_low <= 1'b0;
		hp();
	endtask
	// Data only moves while the clock is low
	task automatic bit_io(input logic b, output logic s);
		sda_low <= ~b;
		hp();
		scl <= 1'b1;
		hp();
		s = sda;
		scl <= 1'b0;
		hp();
	endtask
	task automatic wbyte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) bit_io(b[i], s);
		bit_io(1'b1, s);
		ack = ~s;
	endtask
	task automatic rbyte(output logic [7:0] b, input logic nack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, s);
			b[i] = s;
		end
		bit_io(nack, s);
	endtask
endmodule
`default_nettype wire

// ---- dv/freq_select_latch_smbus_slave_tb.sv ----
// Purpose: Bench for the select latch and serial register slave
// Assumes: 40 MHz core clock, serial host model on the far side
// Notes:   Register access over APB tasks
`timescale 1ns/100ps
`default_nettype none
module freq_select_latch_smbus_slave_tb
	import fss_pkg::*;
;
	logic core_clk, rst_n, cpu_rail_good_strobe_n;
	logic freq_select_first, freq_select_second, freq_select_second_mid;
	logic smb_scl, sda_low, smb_sda_oe, freq_latched, test_clock_mode;
	logic test_outputs_hiz, test_outputs_refn, psel, penable, pwrite;
	logic pready, pslverr, sda_out;
	logic [1:0]  host_freq_sel;
	logic [63:0] ser_regs;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, r;
	logic        e;
	int          mismatches, checks_done;
	// Open drain with pull-up
	wire logic sda = ~(sda_low | smb_sda_oe);
	fss_top DUT (.core_clk, .rst_n, .cpu_rail_good_strobe_n, .freq_select_first,
		.freq_select_second, .freq_select_second_mid, .smb_scl, .smb_sda_in(sda),
		.smb_sda_out(sda_out), .smb_sda_oe, .host_freq_sel, .freq_latched, .test_clock_mode,
		.test_outputs_hiz, .test_outputs_refn, .ser_regs, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr);
	fss_smb_host host (.core_clk, .sda, .scl(smb_scl), .sda_low);
	always #12.5 core_clk = ~core_clk;
	////////////////////////////////////////////////////////////////////////
	task automatic conclude();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic ck(input logic [63:0] got, input logic [63:0] exp, input string m);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: %s", $time, m);
		end
	endtask
	task automatic rst();
		rst_n <= 1'b0;
		repeat (6) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
	endtask
	task automatic wt();
		for (int n = 0; n < 40 && freq_latched !== 1'b1 && test_clock_mode !== 1'b1; n++)
			@(posedge core_clk);
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		// Only the watchdog ends a wait
		do begin
			@(posedge core_clk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Idle edge so a following call never reassigns psel in this step
		@(posedge core_clk);
	endtask
	task automatic sw(input logic [7:0] q[$], input logic ex);
		logic k;
		host.start();
		foreach (q[i]) begin
			host.wbyte(q[i], k);
			ck(k, ex, "write ack");
		end
		host.stop();
	endtask
	task automatic sr(input logic [7:0] c, input logic [7:0] ex[$]);
		logic k;
		logic [7:0] b;
		host.start();
		host.wbyte(SER_ADDR_BYTE, k);
		host.wbyte(c, k);
		ck(k, 1'b1, "command ack");
		host.start();
		host.wbyte(SER_ADDR_BYTE | 8'h01, k);
		ck(k, 1'b1, "read address ack");
		foreach (ex[i]) begin
			host.rbyte(b, i == ex.size() - 1);
			ck(b, ex[i], "read byte");
		end
		host.stop();
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (80000) @(posedge core_clk);
		mismatches++;
		conclude();
	end
	initial begin
		core_clk = 0;
		rst_n = 0;
		cpu_rail_good_strobe_n = 1;
		freq_select_first = 1;
		freq_select_second = 0;
		freq_select_second_mid = 0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		rst();
		ck(ser_regs, SER_DEFAULTS, "defaults");
		ck(sda_out, 1'b0, "open drain data");
		cpu_rail_good_strobe_n <= 1'b0;
		wt();
		ck({freq_latched, host_freq_sel}, 3'b101, "latched selects");
		freq_select_first <= 1'b0;
		freq_select_second <= 1'b1;
		cpu_rail_good_strobe_n <= 1'b1;
		repeat (6) @(posedge core_clk);
		cpu_rail_good_strobe_n <= 1'b0;
		repeat (8) @(posedge core_clk);
		ck(host_freq_sel, 2'b01, "latch frozen");
		apb(1'b0, OFS_STATUS, '0);
		ck(r, 32'h0000_0005, "status");
		sw('{SER_ADDR_BYTE, 8'h83, 8'h5A}, 1'b1);
		ck(ser_regs[31:24], 8'h5A, "byte write");
		sr(8'h83, '{8'h5A});
		sw('{SER_ADDR_BYTE, 8'h00, 8'h02, 8'h11, 8'h22}, 1'b1);
		sr(8'h00, '{SER_COUNT, 8'h11, 8'h22, 8'h00});
		sw('{8'hA0, 8'h83, 8'h00}, 1'b0);
		ck(ser_regs[31:24], 8'h5A, "foreign ignored");
		apb(1'b0, OFS_WIN_BASE + 8'h0C, '0);
		ck(r, 32'h0000_005A, "window byte");
		apb(1'b0, 8'h10, '0);
		ck({e, r}, 33'h1_0000_0000, "unmapped");
		apb(1'b1, OFS_CTRL, '0);
		sw('{SER_ADDR_BYTE}, 1'b0);
		apb(1'b1, OFS_CTRL, 32'h0000_0001);
		apb(1'b0, OFS_CTRL, '0);
		ck(r, 32'h0000_0001, "enable readback");
		sw('{SER_ADDR_BYTE}, 1'b1);
		freq_select_second_mid <= 1'b1;
		freq_select_first <= 1'b1;
		cpu_rail_good_strobe_n <= 1'b1;
		rst();
		cpu_rail_good_strobe_n <= 1'b0;
		wt();
		ck({test_clock_mode, host_freq_sel}, 3'b100, "test mode");
		#1 ck({test_outputs_hiz, test_outputs_refn}, 2'b10, "hi-z");
		@(posedge core_clk);
		freq_select_first <= 1'b0;
		freq_select_second <= 1'b0;
		#1 ck({test_outputs_hiz, test_outputs_refn}, 2'b01, "ref/n");
		repeat (8) @(posedge core_clk);
		ck(test_clock_mode, 1'b1, "test held");
		apb(1'b0, OFS_STATUS, '0);
		ck(r, 32'h0000_0003, "test status");
		freq_select_second_mid <= 1'b0;
		freq_select_second <= 1'b1;
		cpu_rail_good_strobe_n <= 1'b1;
		rst();
		ck(test_clock_mode, 1'b0, "test left");
		cpu_rail_good_strobe_n <= 1'b0;
		wt();
		ck({test_clock_mode, host_freq_sel}, 3'b010, "normal relatch");
		conclude();
	end
endmodule
`default_nettype wire
